/* File: video_switch_serial_control.sv */
// Video switch control port: 3-wire write port and I2C slave on one register.
// Assumes pins are asynchronous; power-down pin is sampled as reset.
`timescale 1ns/1ps
module video_switch_serial_control
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET,
    // Mode pins
    input wire logic POWER_DOWN_N,
    input wire logic PARALLEL_MODE,
    input wire logic BUS_SELECT_I2C,
    input wire logic CHIP_ADDR_PIN_HI,
    input wire logic CHIP_ADDR_PIN_LO,
    // 3-wire port
    input wire logic CHIP_SELECT_N,
    input wire logic CONTROL_CLOCK,
    input wire logic CONTROL_DATA_IN,
    // I2C port
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // Selector state
    output vsw_pkg::selector_t SELECT,
    output logic POWERED_DOWN
);
    logic [4:0] pins_s;
    logic pd_s, cad_hi, cad_lo;
    logic [2:0] misc_s;
    vsw_sync #(.W(5)) u_sync (.clk(CLK_SYS), .rst(RESET),
        .d({CHIP_SELECT_N, CONTROL_CLOCK, CONTROL_DATA_IN, SCL_IN, SDA_IN}), .q(pins_s));
    vsw_sync #(.W(3)) u_sync_m (.clk(CLK_SYS), .rst(RESET),
        .d({POWER_DOWN_N, CHIP_ADDR_PIN_HI, CHIP_ADDR_PIN_LO}), .q(misc_s));
    assign pd_s = misc_s[2];
    assign cad_hi = misc_s[1];
    assign cad_lo = misc_s[0];
    logic mode_i2c_s, par_s;
    logic [1:0] mode_meta;
    always_ff @(posedge CLK_SYS)
    begin
        mode_meta <= {BUS_SELECT_I2C, PARALLEL_MODE};
        {mode_i2c_s, par_s} <= mode_meta;
    end
    wire chip_select_n = pins_s[4];
    wire ccl = pins_s[3];
    wire cdi = pins_s[2];
    wire scl = pins_s[1];
    wire sda = pins_s[0];
    logic ccl_d, scl_d, sda_d;
    wire rst_all = RESET | ~pd_s;
    wire serial_on = ~par_s;
    wire use_three = serial_on & ~mode_i2c_s;
    wire use_i2c = serial_on & mode_i2c_s;
    wire ccl_rise = ccl & ~ccl_d;
    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    wire i2c_start = scl & scl_d & sda_d & ~sda;
    wire i2c_stop = scl & scl_d & ~sda_d & sda;
    always_ff @(posedge CLK_SYS)
    begin
        ccl_d <= ccl;
        scl_d <= scl;
        sda_d <= sda;
    end
    logic [7:0] sel_reg;
    // 3-wire receiver
    logic [14:0] tw_shift;
    logic [4:0] tw_cnt;
    wire [15:0] tw_frame = {tw_shift, cdi};
    wire tw_last = use_three & ~chip_select_n & ccl_rise & (tw_cnt == 5'(vsw_pkg::FRAME_BITS - 1));
    wire tw_match = tw_frame[15:14] == {cad_hi, cad_lo};
    wire tw_write = tw_last & tw_match & tw_frame[13] & (tw_frame[12:8] == vsw_pkg::REG_SELECT);
    always_ff @(posedge CLK_SYS)
    begin
        if (rst_all | chip_select_n)
        begin
            tw_cnt <= 5'h00;
            tw_shift <= 15'h0000;
        end
        else if (use_three & ccl_rise & (tw_cnt < 5'(vsw_pkg::FRAME_BITS)))
        begin
            tw_cnt <= tw_cnt + 5'h01;
            tw_shift <= {tw_shift[13:0], cdi};
        end
    end
    // I2C slave
    vsw_pkg::i2c_state_t st;
    logic [7:0] sh;
    logic [3:0] bc;
    logic rd, got_reg, addr_ctr;
    wire addr_hit = sh[7:1] == {vsw_pkg::I2C_ADDR_FIXED, cad_hi, cad_lo};
    wire [7:0] rd_data = addr_ctr ? 8'h00 : sel_reg;
    wire i2c_wr = use_i2c & (st == vsw_pkg::I_RXB) & scl_fall & (bc == 4'h8) & got_reg
        & ~addr_ctr;
    always_ff @(posedge CLK_SYS)
    begin
        if (rst_all | ~use_i2c)
        begin
            st <= vsw_pkg::I_IDLE;
            sh <= 8'h00;
            bc <= 4'h0;
            rd <= 1'b0;
            got_reg <= 1'b0;
            SDA_OE <= 1'b0;
            if (rst_all)
                addr_ctr <= 1'b0;
        end
        else if (i2c_stop)
        begin
            st <= vsw_pkg::I_IDLE;
            SDA_OE <= 1'b0;
        end
        else if (i2c_start)
        begin
            st <= vsw_pkg::I_ADDR;
            bc <= 4'h0;
            got_reg <= 1'b0;
            SDA_OE <= 1'b0;
        end
        else
        begin
            case (st)
                vsw_pkg::I_IDLE:
                    SDA_OE <= 1'b0;
                vsw_pkg::I_ADDR, vsw_pkg::I_RXB:
                begin
                    if (scl_rise)
                    begin
                        sh <= {sh[6:0], sda};
                        bc <= bc + 4'h1;
                    end
                    else if (scl_fall & (bc == 4'h8))
                    begin
                        bc <= 4'h0;
                        if (st == vsw_pkg::I_ADDR)
                        begin
                            rd <= sh[0];
                            SDA_OE <= addr_hit;
                            st <= addr_hit ? vsw_pkg::I_ACK : vsw_pkg::I_IDLE;
                        end
                        else
                        begin
                            SDA_OE <= 1'b1;
                            st <= vsw_pkg::I_ACK;
                            if (!got_reg)
                            begin
                                addr_ctr <= sh[0];
                                got_reg <= 1'b1;
                            end
                            else
                                addr_ctr <= ~addr_ctr;
                        end
                    end
                end
                vsw_pkg::I_ACK:
                    if (scl_fall)
                    begin
                        if (rd)
                        begin
                            st <= vsw_pkg::I_TXB;
                            sh <= {rd_data[6:0], 1'b0};
                            SDA_OE <= ~rd_data[7];
                            bc <= 4'h1;
                            addr_ctr <= ~addr_ctr;
                        end
                        else
                        begin
                            st <= vsw_pkg::I_RXB;
                            SDA_OE <= 1'b0;
                        end
                    end
                vsw_pkg::I_TXB:
                    if (scl_fall)
                    begin
                        if (bc == 4'h8)
                        begin
                            SDA_OE <= 1'b0;
                            st <= vsw_pkg::I_TACK;
                        end
                        else
                        begin
                            SDA_OE <= ~sh[7];
                            sh <= {sh[6:0], 1'b0};
                            bc <= bc + 4'h1;
                        end
                    end
                vsw_pkg::I_TACK:
                    if (scl_rise)
                        st <= sda ? vsw_pkg::I_IDLE : vsw_pkg::I_ACK;
                default:
                    st <= vsw_pkg::I_IDLE;
            endcase
        end
    end
    assign SDA_OUT = 1'b0;
    // Selector register
    always_ff @(posedge CLK_SYS)
    begin
        if (rst_all)
            sel_reg <= vsw_pkg::SEL_RESET;
        else if (tw_write & tw_match)
            sel_reg <= tw_frame[7:0] & vsw_pkg::SEL_MASK;
        else if (i2c_wr)
            sel_reg <= sh & vsw_pkg::SEL_MASK;
    end
    always_ff @(posedge CLK_SYS)
    begin
        if (rst_all)
        begin
            SELECT <= '0;
            POWERED_DOWN <= 1'b1;
        end
        else
        begin
            SELECT.second_output_select <= sel_reg[vsw_pkg::SEL_HI_LSB +: 3];
            SELECT.first_output_select <= sel_reg[vsw_pkg::SEL_LO_LSB +: 3];
            POWERED_DOWN <= 1'b0;
        end
    end
endmodule

/* File: vsw_pkg.sv */
// Package: constants and types for the video switch serial control port.
// Assumes a 100 MHz system clock samples all serial pins.
// Notes on behaviour
// - Power-down low clears register, grounds outputs
// - First selector: zero off, else input N
// - Second selector: same mapping as first
// - Bus-select low 3-wire, high I2C
// - 3-wire frame: chip addr, write, addr, data
// - 3-wire acts only on chip address match
// - 3-wire samples data on clock rise
// - Latch on sixteenth clock rise
// - I2C runs at fast-mode rates
// - Slave address fixed pattern plus pins
// - Acknowledge every byte received in write
// - Address counter increments, wraps to zero
// - Current read returns next address byte
// - Data changes only while clock low
// - Serial port active only in serial mode
package vsw_pkg;
    localparam logic [4:0] I2C_ADDR_FIXED = 5'h04;
    localparam int FRAME_BITS = 16;
    localparam int SEL_HI_LSB = 4;
    localparam int SEL_LO_LSB = 0;
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [7:0] SEL_MASK = 8'h77;
    localparam logic [4:0] REG_SELECT = 5'h00;
    localparam logic [4:0] REG_TOP = 5'h01;
    localparam int SCLK_MHZ = 100;
    localparam int CONTROL_CLOCK_MAX_KHZ = 5000;
    localparam int SCL_MAX_KHZ = 400;
    typedef struct packed
    {
        logic [2:0] second_output_select;
        logic [2:0] first_output_select;
    } selector_t;
    typedef enum logic [2:0] {I_IDLE, I_ADDR, I_ACK, I_RXB, I_TXB, I_TACK} i2c_state_t;
endpackage

/* File: vsw_sync.sv */
// Two-flop synchroniser for the serial pins.
// Assumes inputs are asynchronous to CLK_SYS.
`timescale 1ns/1ps
module vsw_sync #(parameter int W = 5)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta <= '1;
            q <= '1;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

/* File: vsw_monitor.sv */
// Checker for the video switch control port.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ps
module vsw_monitor
(
    // Watched ports
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic POWER_DOWN_N,
    input wire logic PARALLEL_MODE,
    input wire logic BUS_SELECT_I2C,
    input wire logic SCL_IN,
    input wire logic SDA_OE,
    input wire vsw_pkg::selector_t SELECT,
    input wire logic POWERED_DOWN
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    a_pd_clear: assert property (
        !POWER_DOWN_N [*5] |-> SELECT == 6'h00 && !SDA_OE && POWERED_DOWN) else $error("pd");
    a_rst_clear: assert property (
        disable iff (1'b0) RESET |=> SELECT == 6'h00 && POWERED_DOWN) else $error("rst");
    a_pd_flag: assert property (POWER_DOWN_N [*6] |-> !POWERED_DOWN)
        else $error("flag stuck");
    a_wire_quiet: assert property (!BUS_SELECT_I2C [*8] |-> !SDA_OE)
        else $error("ack in 3-wire");
    a_par_hold: assert property (
        PARALLEL_MODE [*6] ##0 POWER_DOWN_N |=> $stable(SELECT)) else $error("par write");
    a_sel_cause: assert property (
        $changed(SELECT) && POWER_DOWN_N |-> !$past(PARALLEL_MODE, 3)) else $error("cause");
    a_oe_scl: assert property ($changed(SDA_OE) |-> !SCL_IN)
        else $error("sda moved");
    a_ack_len: assert property ($rose(SDA_OE) |-> SDA_OE [*8])
        else $error("short drive");
    cover property ($rose(SDA_OE));
    cover property ($changed(SELECT));
    cover property ($fell(POWERED_DOWN));
endmodule
bind video_switch_serial_control vsw_monitor i_mon
(
    .CLK_SYS(CLK_SYS), .RESET(RESET), .POWER_DOWN_N(POWER_DOWN_N),
    .PARALLEL_MODE(PARALLEL_MODE), .BUS_SELECT_I2C(BUS_SELECT_I2C), .SCL_IN(SCL_IN),
    .SDA_OE(SDA_OE), .SELECT(SELECT), .POWERED_DOWN(POWERED_DOWN)
);

/* File: vsw_host.sv */
// Host master model for the 3-wire and I2C ports.
// Assumes SDA has a pull-up and the device only pulls it low.
`timescale 1ns/1ps
module vsw_host
(
    // Device side
    input wire logic dut_oe,
    input wire logic dut_out,
    // Host pins
    output logic chip_select_n = 1'b1,
    output logic control_clock = 1'b0,
    output logic control_data_in = 1'b0,
    output logic scl = 1'b1,
    output logic sda
);
    logic m_low = 1'b0;
    assign sda = !m_low && (!dut_oe || dut_out);
    task automatic wr3(input logic [15:0] f, input int n);
        chip_select_n = 1'b0;
        for (int i = 15; i > 15 - n; i--)
        begin
            control_data_in = f[i];
            #62.5 control_clock = 1'b1;
            #62.5 control_clock = 1'b0;
        end
        control_data_in = ~control_data_in;
        #60 chip_select_n = 1'b1;
        #200;
    endtask
    task automatic bit_io(input logic b, output logic s);
        #300 m_low = !b;
        #1000 scl = 1'b1;
        #600 s = sda;
        #600 scl = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] b, input logic last, output logic [7:0] r,
        output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r[i]);
        bit_io(last, s);
        ack = !s;
    endtask
    task automatic start();
        #300 m_low = 1'b0;
        #1000 scl = 1'b1;
        #600 m_low = 1'b1;
        #600 scl = 1'b0;
    endtask
    task automatic stop();
        #300 m_low = 1'b1;
        #1000 scl = 1'b1;
        #600 m_low = 1'b0;
        #1300;
    endtask
endmodule

/* File: video_switch_serial_control_tb.sv */
// Self-checking bench for the video switch control port.
// Assumes the host model drives the serial pins.
`timescale 1ns/1ps
`define CHK(g, e) check((g) === (e), 8'(g), 8'(e))
module video_switch_serial_control_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic power_down_n = 1'b1;
    logic par = 1'b0;
    logic i2c = 1'b0;
    logic chip_select_n, control_clock, control_data_in, scl, sda, sdo, oe, pd, a;
    logic cah = 1'b1;
    logic cal = 1'b0;
    vsw_pkg::selector_t sel;
    logic [7:0] r;
    logic [15:0] bad [4] = '{16'h6022, 16'h8022, 16'ha122, 16'ha022};
    int miscompares = 0;
    int check_count = 0;
    localparam logic [6:0] SA = {5'h04, 2'b10};
    always #5 clk = ~clk;
    video_switch_serial_control i_dut
    (
        .CLK_SYS(clk), .RESET(rst), .POWER_DOWN_N(power_down_n), .PARALLEL_MODE(par),
        .BUS_SELECT_I2C(i2c), .CHIP_ADDR_PIN_HI(cah), .CHIP_ADDR_PIN_LO(cal),
        .CHIP_SELECT_N(chip_select_n), .CONTROL_CLOCK(control_clock), .CONTROL_DATA_IN(control_data_in), .SCL_IN(scl),
        .SDA_IN(sda), .SDA_OUT(sdo), .SDA_OE(oe), .SELECT(sel), .POWERED_DOWN(pd)
    );
    vsw_host h (.dut_oe(oe), .dut_out(sdo), .chip_select_n(chip_select_n), .control_clock(control_clock), .control_data_in(control_data_in),
        .scl(scl), .sda(sda));
    task automatic check(input bit ok, input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (!ok)
        begin
            miscompares++;
            $display("unexpected at %0t: %h vs %h", $time, g, e);
        end
    endtask
    task automatic summarize();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic iwr(input logic [7:0] q[$], input logic ea, input logic fin);
        h.start();
        foreach (q[i])
        begin
            h.xfer(q[i], 1'b1, r, a);
            `CHK(a, ea);
        end
        if (fin)
            h.stop();
    endtask
    task automatic ird(input logic [7:0] e[$]);
        h.start();
        h.xfer({SA, 1'b1}, 1'b1, r, a);
        `CHK(a, 1'b1);
        foreach (e[i])
        begin
            h.xfer(8'hff, i == e.size() - 1, r, a);
            `CHK(r, e[i]);
        end
        h.stop();
    endtask
    initial
    begin
        cyc(2);
        `CHK(pd, 1'b1);
        rst = 1'b0;
        cyc(8);
        `CHK(pd, 1'b0);
        for (int v = 1; v < 8; v++)
        begin
            h.wr3({2'b10, 1'b1, 5'h00, 1'b0, 3'(v), 1'b0, 3'(8 - v)}, 16);
            `CHK(sel, {3'(v), 3'(8 - v)});
        end
        for (int i = 0; i < 4; i++)
        begin
            h.wr3(bad[i], i == 3 ? 15 : 16);
            `CHK(sel, 6'h39);
        end
        {cah, cal} = 2'b01;
        cyc(8);
        h.wr3(16'h6044, 16);
        `CHK(sel, 6'h24);
        {cah, cal} = 2'b10;
        par = 1'b1;
        cyc(8);
        h.wr3(16'ha022, 16);
        `CHK(sel, 6'h24);
        par = 1'b0;
        i2c = 1'b1;
        cyc(8);
        h.wr3(16'ha022, 16);
        `CHK(sel, 6'h24);
        iwr('{{SA, 1'b0}, 8'h00, 8'h53}, 1'b1, 1'b1);
        `CHK(sel, 6'h2b);
        iwr('{{SA ^ 7'h01, 1'b0}, 8'h00, 8'h11}, 1'b0, 1'b1);
        `CHK(sel, 6'h2b);
        iwr('{{SA, 1'b0}, 8'h00, 8'h12, 8'h99, 8'h34}, 1'b1, 1'b1);
        `CHK(sel, 6'h1c);
        ird('{8'h00, 8'h34});
        iwr('{{SA, 1'b0}, 8'h00, 8'hff}, 1'b1, 1'b1);
        iwr('{{SA, 1'b0}, 8'h00}, 1'b1, 1'b0);
        ird('{8'h77});
        power_down_n = 1'b0;
        cyc(10);
        `CHK(sel, 6'h00);
        `CHK(pd, 1'b1);
        power_down_n = 1'b1;
        summarize();
    end
    initial
    begin
        #800us;
        miscompares++;
        summarize();
    end
endmodule
